// File: hdl/ambz_defs.vh
/*
 Register offsets, field positions and timing counts for the memory
 self-test and zeroize controller. Assumes inclusion by bare name.
*/
`ifndef AMBZ_DEFS_VH
`define AMBZ_DEFS_VH

`define AMBZ_ADDR_CTRL 12'h00C
`define AMBZ_ADDR_IRQ_STAT 12'h010
`define AMBZ_ADDR_IRQ_EN 12'h014
`define AMBZ_ADDR_IRQ_CLR 12'h018

`define AMBZ_B_SBIST 0
`define AMBZ_B_SZERO 1
`define AMBZ_B_MBIST 2
`define AMBZ_B_MZERO 3
`define AMBZ_B_TBIST 4
`define AMBZ_B_TZERO 5
`define AMBZ_B_BBIST 6
`define AMBZ_SEL_LSB 8
`define AMBZ_SEL_MSB 13
`define AMBZ_SEL_W 6
`define AMBZ_B_SFAIL 14
`define AMBZ_B_SDONE 15
`define AMBZ_B_SZDONE 16
`define AMBZ_B_MFAIL 17
`define AMBZ_B_MDONE 18
`define AMBZ_B_MZDONE 19
`define AMBZ_B_TFAIL 20
`define AMBZ_B_TDONE 21
`define AMBZ_B_TZDONE 22
`define AMBZ_B_BFAIL 23
`define AMBZ_B_BDONE 24
`define AMBZ_B_ZDONE 25
`define AMBZ_B_BISTDONE 26
`define AMBZ_B_BISTFAIL 27

`define AMBZ_NUM_OPS 7
`define AMBZ_BIST_WORDS 64
`define AMBZ_ZERO_WORDS 64
`define AMBZ_CNT_W 16

`endif

// File: hdl/ambz_ctrl.v
/*
 Memory self-test and zeroize control for one processor array, with an
 APB slave for its registers and one level interrupt.
 Assumes APB master signals synchronous to clock; one clock domain.
*/
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ambz_defs.vh"

// Summary of operation
// - Setting bit 6 runs self-test over every bias memory and reports bias group and common done/fail.
// - Setting bit 5 zero-fills every t_memory word, then raises its zeroize-done and common zeroize-done.
// - The t_memory zeroize starts only on a zero-to-one change of its bit.
// - Setting bit 4 self-tests all t_memory instances and reports group and common done/fail.
// - Setting bit 3 zero-fills every m_memory word and reports its zeroize-done and common zeroize-done.
// - Setting bit 2 self-tests all m_memory instances and reports group and common done/fail.
// - Setting bit 1 zero-fills every data SRAM word and reports its zeroize-done and common zeroize-done.
// - Setting bit 0 self-tests all data SRAM instances and reports group and common done/fail.
// - A started self-test runs uninterrupted over all selected instances before its done is raised.
// - Writing one to a run bit that already holds one does not start a new pass.
// - Repeated ones on a zeroize bit start no new pass; software clears the bit first.
// - Software can read detailed results of one controller chosen by the select field.
// - Select bit 5 picks the SRAM/bias group with low bits as instance, 100 being bias; bit 4 m, bit 3 t.
// - The SRAM group fail flag holds the finished result and clears when the SRAM run bit is written zero.
module ambz_ctrl #(
    parameter NUM_INST = 4,
    parameter BIST_WORDS = `AMBZ_BIST_WORDS,
    parameter ZERO_WORDS = `AMBZ_ZERO_WORDS
) (
    input wire clock,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [NUM_INST*`AMBZ_NUM_OPS-1:0] instFail,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg memWriteZero,
    output reg [`AMBZ_NUM_OPS-1:0] opBusy,
    output reg irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [`AMBZ_NUM_OPS-1:0] trig_r;
    reg [`AMBZ_SEL_W-1:0] sel_r;
    reg [`AMBZ_NUM_OPS-1:0] done_r;
    reg [`AMBZ_NUM_OPS-1:0] fail_r;
    reg [NUM_INST*`AMBZ_NUM_OPS-1:0] instFail_r;
    reg [`AMBZ_NUM_OPS-1:0] irqStat_r;
    reg [`AMBZ_NUM_OPS-1:0] irqEn_r;
    wire [`AMBZ_NUM_OPS-1:0] doneRise;
    wire apbAccess = psel & penable & ~pready;
    wire wrEn = apbAccess & pwrite;
    wire ctrlWr = wrEn & (paddr == `AMBZ_ADDR_CTRL);
    wire [`AMBZ_NUM_OPS-1:0] wrTrig = pwdata[`AMBZ_NUM_OPS-1:0];
    wire mapped = (paddr == `AMBZ_ADDR_CTRL) | (paddr == `AMBZ_ADDR_IRQ_STAT) |
                  (paddr == `AMBZ_ADDR_IRQ_EN) | (paddr == `AMBZ_ADDR_IRQ_CLR);
    wire bistAllDone = |(done_r & 7'h55);
    wire bistAnyFail = |(fail_r & 7'h55);
    wire zeroAllDone = |(done_r & 7'h2A);
    wire [`AMBZ_NUM_OPS-1:0] zeroOp = 7'h2A;

    // One engine per trigger bit; bit index selects bist or zeroize flavour
    genvar g;
    generate
        for (g = 0; g < `AMBZ_NUM_OPS; g = g + 1) begin : gOp
            reg [2:0] st_r;
            reg [2:0] st_nxt;
            reg [`AMBZ_CNT_W-1:0] cnt_r;
            wire [`AMBZ_CNT_W-1:0] lastCnt = (g == `AMBZ_B_SZERO || g == `AMBZ_B_MZERO || g == `AMBZ_B_TZERO) ?
                                              ZERO_WORDS[`AMBZ_CNT_W-1:0] - 16'h0001 :
                                              BIST_WORDS[`AMBZ_CNT_W-1:0] - 16'h0001;
            // Start only on a written rising edge of the trigger bit
            wire start = ctrlWr & wrTrig[g] & ~trig_r[g];
            wire clr = ctrlWr & ~wrTrig[g];
            always @* begin
                st_nxt = st_r;
                case (st_r)
                    ST_IDLE: if (start) st_nxt = ST_RUN;
                    // Clearing the bit mid-pass does not abort it
                    ST_RUN: if (cnt_r == lastCnt) st_nxt = ST_DONE;
                    ST_DONE: if (clr) st_nxt = ST_IDLE;
                    default: st_nxt = ST_IDLE;
                endcase
            end
            always @(posedge clock) begin
                if (sys_rst) begin
                    st_r <= ST_IDLE;
                    cnt_r <= {`AMBZ_CNT_W{1'b0}};
                    done_r[g] <= 1'b0;
                    fail_r[g] <= 1'b0;
                    instFail_r[g*NUM_INST +: NUM_INST] <= {NUM_INST{1'b0}};
                end else begin
                    st_r <= st_nxt;
                    cnt_r <= (st_r == ST_RUN) ? cnt_r + 16'h0001 : {`AMBZ_CNT_W{1'b0}};
                    if (st_r == ST_RUN)
                        instFail_r[g*NUM_INST +: NUM_INST] <= instFail_r[g*NUM_INST +: NUM_INST] |
                                                                instFail[g*NUM_INST +: NUM_INST];
                    else if (start)
                        instFail_r[g*NUM_INST +: NUM_INST] <= {NUM_INST{1'b0}};
                    if (st_r == ST_RUN && st_nxt == ST_DONE) begin
                        done_r[g] <= 1'b1;
                        fail_r[g] <= ~zeroOp[g] & (|(instFail_r[g*NUM_INST +: NUM_INST] |
                                                      instFail[g*NUM_INST +: NUM_INST]));
                    end else if (st_nxt == ST_IDLE) begin
                        done_r[g] <= 1'b0;
                        fail_r[g] <= 1'b0;
                    end
                end
            end
            assign doneRise[g] = (st_r == ST_RUN) && (st_nxt == ST_DONE);
        end
    endgenerate

    // Detailed per-controller view chosen by the select field
    reg [31:0] detail;
    always @* begin
        detail = 32'h0000_0000;
        if (sel_r[5]) begin
            if (sel_r[2:0] == 3'h4) begin
                detail[0] = done_r[`AMBZ_B_BBIST];
                detail[1] = fail_r[`AMBZ_B_BBIST];
                detail[NUM_INST+1:2] = instFail_r[`AMBZ_B_BBIST*NUM_INST +: NUM_INST];
            end else begin
                detail[0] = done_r[`AMBZ_B_SBIST];
                detail[1] = (sel_r[2:0] < NUM_INST) ? instFail_r[`AMBZ_B_SBIST*NUM_INST + sel_r[1:0]] : 1'b0;
            end
        end else if (sel_r[4]) begin
            detail[0] = done_r[`AMBZ_B_MBIST];
            detail[1] = (sel_r[3:0] < NUM_INST) ? instFail_r[`AMBZ_B_MBIST*NUM_INST + sel_r[1:0]] : 1'b0;
        end else if (sel_r[3]) begin
            detail[0] = done_r[`AMBZ_B_TBIST];
            detail[1] = (sel_r[2:0] < NUM_INST) ? instFail_r[`AMBZ_B_TBIST*NUM_INST + sel_r[1:0]] : 1'b0;
        end
    end

    reg [31:0] ctrlRead;
    always @* begin
        ctrlRead = 32'h0000_0000;
        ctrlRead[`AMBZ_NUM_OPS-1:0] = trig_r;
        ctrlRead[`AMBZ_SEL_MSB:`AMBZ_SEL_LSB] = sel_r;
        ctrlRead[`AMBZ_B_SFAIL] = fail_r[`AMBZ_B_SBIST];
        ctrlRead[`AMBZ_B_SDONE] = done_r[`AMBZ_B_SBIST];
        ctrlRead[`AMBZ_B_SZDONE] = done_r[`AMBZ_B_SZERO];
        ctrlRead[`AMBZ_B_MFAIL] = fail_r[`AMBZ_B_MBIST];
        ctrlRead[`AMBZ_B_MDONE] = done_r[`AMBZ_B_MBIST];
        ctrlRead[`AMBZ_B_MZDONE] = done_r[`AMBZ_B_MZERO];
        ctrlRead[`AMBZ_B_TFAIL] = fail_r[`AMBZ_B_TBIST];
        ctrlRead[`AMBZ_B_TDONE] = done_r[`AMBZ_B_TBIST];
        ctrlRead[`AMBZ_B_TZDONE] = done_r[`AMBZ_B_TZERO];
        ctrlRead[`AMBZ_B_BFAIL] = fail_r[`AMBZ_B_BBIST];
        ctrlRead[`AMBZ_B_BDONE] = done_r[`AMBZ_B_BBIST];
        ctrlRead[`AMBZ_B_ZDONE] = zeroAllDone;
        ctrlRead[`AMBZ_B_BISTDONE] = bistAllDone;
        ctrlRead[`AMBZ_B_BISTFAIL] = bistAnyFail;
    end

    reg [31:0] rdData;
    always @* begin
        rdData = 32'h0000_0000;
        case (paddr)
            `AMBZ_ADDR_CTRL: rdData = ctrlRead;
            // Lower half of the detail view is folded into the upper half of the status register read
            `AMBZ_ADDR_IRQ_STAT: rdData = {detail[15:0], 9'h000, irqStat_r};
            `AMBZ_ADDR_IRQ_EN: rdData = {25'h0000000, irqEn_r};
            default: rdData = 32'h0000_0000;
        endcase
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            trig_r <= {`AMBZ_NUM_OPS{1'b0}};
            sel_r <= {`AMBZ_SEL_W{1'b0}};
            irqStat_r <= {`AMBZ_NUM_OPS{1'b0}};
            irqEn_r <= {`AMBZ_NUM_OPS{1'b0}};
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            memWriteZero <= 1'b0;
            opBusy <= {`AMBZ_NUM_OPS{1'b0}};
            irq <= 1'b0;
        end else begin
            pready <= apbAccess;
            pslverr <= apbAccess & ~mapped;
            prdata <= (apbAccess & ~pwrite) ? rdData : 32'h0000_0000;
            if (ctrlWr) begin
                trig_r <= wrTrig;
                sel_r <= pwdata[`AMBZ_SEL_MSB:`AMBZ_SEL_LSB];
            end
            if (wrEn && paddr == `AMBZ_ADDR_IRQ_EN)
                irqEn_r <= pwdata[`AMBZ_NUM_OPS-1:0];
            // A completion in the clearing cycle survives the clear
            irqStat_r <= (wrEn && paddr == `AMBZ_ADDR_IRQ_CLR) ?
                         ((irqStat_r & ~pwdata[`AMBZ_NUM_OPS-1:0]) | doneRise) : (irqStat_r | doneRise);
            irq <= |((irqStat_r | doneRise) & irqEn_r);
            opBusy <= {gOp[6].st_r[1], gOp[5].st_r[1], gOp[4].st_r[1], gOp[3].st_r[1],
                       gOp[2].st_r[1], gOp[1].st_r[1], gOp[0].st_r[1]};
            memWriteZero <= gOp[1].st_r[1] | gOp[3].st_r[1] | gOp[5].st_r[1];
        end
    end
endmodule // ambz_ctrl

`default_nettype wire

// File: sim/ambz_checker.sv
/* Port assertions for the memory test and zeroize controller.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module ambz_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic memWriteZero,
    input wire logic [6:0] opBusy,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire ctrlWr = psel && pwrite && paddr == 12'h00C;
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    chk_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access phase");
    chk_err_map: assert property (pslverr |-> pready && !(paddr inside {12'h00C, 12'h010, 12'h014, 12'h018}))
        else $error("pslverr on mapped address");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    chk_sbist_run: assert property ($rose(opBusy[0]) |-> opBusy[0] [*8])
        else $error("sram self-test cut short");
    chk_mzero_run: assert property ($rose(opBusy[3]) |-> opBusy[3] [*8])
        else $error("m_memory zeroize cut short");
    chk_busy_cause: assert property ($rose(|opBusy) |-> $past(ctrlWr) || $past(ctrlWr, 2))
        else $error("operation started without control write");
    chk_tzero_wipe: assert property ($rose(opBusy[5]) |-> ##[0:2] memWriteZero)
        else $error("t_memory zeroize without zero writes");
    cov_err: cover property (pslverr);
    cov_done: cover property ($fell(opBusy[0]));
    cov_irq: cover property ($rose(irq));
endmodule // ambz_checker
bind ambz_ctrl ambz_checker u_chk (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memWriteZero(memWriteZero), .opBusy(opBusy), .irq(irq));
`default_nettype wire

// File: sim/tb_top.sv
/* Self-checking bench for the memory test controller over APB.
   Assumes the design under hdl/ with shortened run counts. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic sysRst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, memWriteZero, irq, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, ex;
    logic [27:0] instFail = 28'h0;
    logic [6:0] opBusy;
    int n_fail = 0, checks = 0;
    int doneB[7] = '{15, 16, 18, 19, 21, 22, 24};
    always #5 clock = ~clock;
    ambz_ctrl #(.NUM_INST(4), .BIST_WORDS(16), .ZERO_WORDS(16)) DUT (.clock(clock), .sys_rst(sysRst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .instFail(instFail),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .memWriteZero(memWriteZero), .opBusy(opBusy), .irq(irq));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Called just after a rising edge; one idle cycle follows so psel never toggles within one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge clock);
        if (k == 20) begin
            n_fail++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask
    task automatic waitBit(input int b);
        for (int k = 0; k < 40; k++) begin
            apb(1'b0, 12'h00C, 32'h0);
            if (rd[b] === 1'b1) return;
        end
        n_fail++;
        tally_and_finish();
    endtask
    initial begin
        repeat (4) @(posedge clock);
        sysRst <= 1'b0;
        @(posedge clock);
        rdchk(12'h00C, '1, 32'h0, "ctrl reset");
        rdchk(12'h020, '1, 32'h0, "unmapped read");
        chk("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b1, 12'h014, 32'h7F);
        for (int g = 0; g < 7; g++) begin
            // Ops 0 and 4 see one failing instance; zeroize ops never fail
            instFail <= (g == 0 || g == 4) ? 28'h1 << (g * 4 + 1) : 28'h0;
            ex = (32'h1 << g) | (32'h1 << doneB[g]) | (g == 6 ? 32'h2400 : 32'h0);
            ex |= (g % 2) ? 32'h0200_0000 : 32'h0400_0000;
            if (g == 0 || g == 4) ex |= (32'h1 << (doneB[g] - 1)) | 32'h0800_0000;
            apb(1'b1, 12'h00C, (32'h1 << g) | (g == 6 ? 32'h2400 : 32'h0));
            chk("op busy", {25'h0, opBusy}, 32'h1 << g);
            chk("zero writes", {31'h0, memWriteZero}, {31'h0, g[0]});
            waitBit(doneB[g]);
            chk("ctrl after run", rd, ex);
            chk("irq raised", {31'h0, irq}, 32'h1);
            rdchk(12'h010, g == 6 ? 32'h1007F : 32'h7F, (32'h1 << g) | (g == 6 ? 32'h10000 : 32'h0), "status");
            apb(1'b1, 12'h018, 32'h1 << g);
            chk("irq cleared", {31'h0, irq}, 32'h0);
            apb(1'b1, 12'h00C, 32'h1 << g);
            chk("no rerun", {25'h0, opBusy}, 32'h0);
            apb(1'b1, 12'h00C, 32'h0);
            rdchk(12'h00C, '1, 32'h0, "ctrl cleared");
        end
        apb(1'b1, 12'h014, 32'h0);
        apb(1'b1, 12'h00C, 32'h1);
        apb(1'b1, 12'h00C, 32'h0);
        chk("run continues", {31'h0, opBusy[0]}, 32'h1);
        waitBit(15);
        chk("done kept", rd, 32'h0400_8000);
        chk("irq masked", {31'h0, irq}, 32'h0);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
